// file: pkg/cdh_pkg.sv
// package for the character display host register and glyph ram block
package cdh_pkg;
   localparam int          DATA_W        = 8;
   localparam int          TEXT_AW       = 7;
   localparam int          GLYPH_AW      = 6;
   localparam int          TEXT_DEPTH    = 128;
   localparam int          GLYPH_DEPTH   = 64;
   // instruction codes of the address-setting group, the direction setting and its bit mask
   localparam logic [7:0]  SET_GLYPH_ADR = 8'h40;
   localparam logic [7:0]  SET_TEXT_ADR  = 8'h80;
   localparam logic [7:0]  SET_DIR       = 8'h04;
   localparam logic [7:0]  DIR_BIT_MASK  = 8'h02;
   // reset values
   localparam logic [7:0]  TEXT_RESET    = 8'h20;
   localparam logic [7:0]  ADDR_RESET    = 8'h00;
   localparam logic        DIR_RESET     = 1'b1;
   // glyph addressing fields
   localparam int          ROW_LSB       = 0;
   localparam int          PAT_LSB       = 3;
   localparam logic [2:0]  CURSOR_ROW    = 3'h7;
   localparam int          DOT_LEFT      = 4;
   // internal operation length in clocks
   localparam int          OP_CYCLES     = 2;
   typedef enum logic [1:0] {
      CDH_IDLE  = 2'b00,
      CDH_WRITE = 2'b01,
      CDH_FETCH = 2'b11
   } cdh_state_t;
endpackage : cdh_pkg

// file: hdl/cdh_core.sv
// host register pair, text and glyph ram, address counter and glyph row lookup
module cdh_core
   import cdh_pkg::*;
(
   input  wire logic                        MCLK_I,
   input  wire logic                        RESETN_I,
   input  wire logic                        REGISTER_SELECT_I,
   input  wire logic                        WR_STROBE_I,
   input  wire logic                        RD_STROBE_I,
   input  wire logic [cdh_pkg::DATA_W-1:0]  DATA_I,
   output logic      [cdh_pkg::DATA_W-1:0]  DATA_O,
   output logic                             DATA_OE_O,
   output logic                             BUSY_INDICATOR_O,
   input  wire logic [cdh_pkg::DATA_W-1:0]  CHAR_CODE_I,
   input  wire logic [2:0]                  ROW_I,
   input  wire logic                        CURSOR_I,
   output logic                             USE_GLYPH_RAM_O,
   output logic      [4:0]                  DOTS_O
);
   import cdh_pkg::*;

   logic [7:0]       instruction_register;
   logic [7:0]       data_staging_register;
   logic [6:0]       address_counter;
   logic             glyph_sel;
   logic             dir_up;
   cdh_state_t       state;
   logic [1:0]       op_cnt;
   logic [7:0]       text_ram  [TEXT_DEPTH];
   logic [7:0]       glyph_ram [GLYPH_DEPTH];
   logic [1:0]       sync_rs, sync_wr, sync_rd;
   logic [7:0]       sync_d1, sync_d2;
   logic             wr_prev, rd_prev;
   logic             wr_ev, rd_ev;
   logic             busy;
   logic [7:0]       ram_q;
   logic [7:0]       pat;

   // pins come from the host's domain: two flops first
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync_rs <= 2'h0;
         sync_wr <= 2'h0;
         sync_rd <= 2'h0;
         sync_d1 <= 8'h00;
         sync_d2 <= 8'h00;
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
      end else begin
         sync_rs <= {sync_rs[0], REGISTER_SELECT_I};
         sync_wr <= {sync_wr[0], WR_STROBE_I};
         sync_rd <= {sync_rd[0], RD_STROBE_I};
         sync_d1 <= DATA_I;
         sync_d2 <= sync_d1;
         wr_prev <= sync_wr[1];
         rd_prev <= sync_rd[1];
      end
   end

   // falling edge of the strobe ends an access; data is stable by then
   assign wr_ev = wr_prev & ~sync_wr[1];
   assign rd_ev = rd_prev & ~sync_rd[1];
   assign busy  = (state != CDH_IDLE);

   // glyph or text location addressed by the counter
   function automatic logic [7:0] ram_at(input logic g, input logic [6:0] a);
      return g ? glyph_ram[a[5:0]] : text_ram[a];
   endfunction

   assign ram_q = ram_at(glyph_sel, address_counter);

   function automatic logic [6:0] step(input logic up, input logic [6:0] a);
      return up ? 7'(a + 7'h01) : 7'(a - 7'h01);
   endfunction

   // internal operation sequencer
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state  <= CDH_IDLE;
         op_cnt <= 2'h0;
      end else begin
         unique case (state)
            CDH_IDLE: begin
               op_cnt <= 2'(OP_CYCLES - 1);
               if (wr_ev && sync_rs[1]) begin
                  state <= CDH_WRITE;
               end else if (wr_ev && (sync_d2[7] || sync_d2[7:6] == 2'b01)) begin
                  state <= CDH_FETCH;
               end else if (rd_ev && sync_rs[1]) begin
                  state <= CDH_FETCH;
               end
            end
            default: begin
               op_cnt <= 2'(op_cnt - 2'h1);
               if (op_cnt == 2'h0) begin
                  state <= CDH_IDLE;
               end
            end
         endcase
      end
   end

   // instruction register and address state; host writes only taken while idle, the counter also steps at the end of a data write
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         instruction_register <= ADDR_RESET;
         address_counter      <= 7'h00;
         glyph_sel            <= 1'b0;
         dir_up               <= DIR_RESET;
      end else if (state == CDH_IDLE && wr_ev && !sync_rs[1]) begin
         instruction_register <= sync_d2;
         if (sync_d2[7]) begin
            address_counter <= sync_d2[6:0];
            glyph_sel       <= 1'b0;
         end else if (sync_d2[7:6] == 2'b01) begin
            address_counter <= {1'b0, sync_d2[5:0]};
            glyph_sel       <= 1'b1;
         end else if (sync_d2[7:2] == 6'h01) begin
            dir_up <= |(sync_d2 & DIR_BIT_MASK);
         end
      end else if (state == CDH_WRITE && op_cnt == 2'h0) begin
         address_counter <= step(dir_up, address_counter);
      end else if (state == CDH_IDLE && rd_ev && sync_rs[1] && !wr_ev) begin
         // step before the prefetch so the next read sees the next address
         address_counter <= step(dir_up, address_counter);
      end
   end

   // ram writes; reset fills text with spaces and blanks the glyphs
   // costs flops, but no fetch can ever load an unknown byte
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         for (int j = 0; j < TEXT_DEPTH; j++) begin
            text_ram[j] <= TEXT_RESET;
         end
         for (int j = 0; j < GLYPH_DEPTH; j++) begin
            glyph_ram[j] <= 8'h00;
         end
      end else if (state == CDH_WRITE && op_cnt == 2'h0) begin
         if (glyph_sel) begin
            glyph_ram[address_counter[5:0]] <= data_staging_register;
         end else begin
            text_ram[address_counter] <= data_staging_register;
         end
      end
   end

   // data staging register: host write, then fetch loads
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         data_staging_register <= 8'h00;
      end else if (state == CDH_IDLE && wr_ev && sync_rs[1]) begin
         data_staging_register <= sync_d2;
      end else if (state == CDH_FETCH && op_cnt == 2'h0) begin
         data_staging_register <= ram_q;
      end
   end

   // read bus: status with select low, staging data with select high
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         DATA_O    <= 8'h00;
         DATA_OE_O <= 1'b0;
      end else begin
         DATA_OE_O <= sync_rd[1];
         DATA_O    <= sync_rs[1] ? data_staging_register
                                 : {busy, address_counter};
      end
   end

   assign BUSY_INDICATOR_O = busy;

   // glyph lookup for the display scan
   assign USE_GLYPH_RAM_O = (CHAR_CODE_I[7:4] == 4'h0);
   assign pat = glyph_ram[{CHAR_CODE_I[2:0], ROW_I}];
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         DOTS_O <= 5'h00;
      end else if (ROW_I == CURSOR_ROW) begin
         DOTS_O <= pat[DOT_LEFT:0] | {5{CURSOR_I}};
      end else begin
         DOTS_O <= pat[DOT_LEFT:0];
      end
   end

   // busy stays high for two clocks from its rise, then drops
   property p_busy_len;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         $rose(busy) |-> busy [*2] ##1 !busy;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

   property p_write_ram;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (state == CDH_IDLE && wr_ev && sync_rs[1]) |=> state == CDH_WRITE;
   endproperty
   a_write_ram: assert property (p_write_ram) else $error("data write not moved");

   property p_fetch_load;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (state == CDH_FETCH && op_cnt == 2'h0) |=> data_staging_register == $past(ram_q);
   endproperty
   a_fetch_load: assert property (p_fetch_load) else $error("fetch not loaded");

   property p_step;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (state == CDH_WRITE && op_cnt == 2'h0 && dir_up)
            |=> address_counter == 7'($past(address_counter) + 7'h01);
   endproperty
   a_step: assert property (p_step) else $error("counter not stepped");

   property p_glyph_sel;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         USE_GLYPH_RAM_O == (CHAR_CODE_I < 8'h10);
   endproperty
   a_glyph_sel: assert property (p_glyph_sel) else $error("glyph select wrong");

   property p_cursor_row;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (ROW_I == CURSOR_ROW && CURSOR_I) |=> DOTS_O == 5'h1f;
   endproperty
   a_cursor_row: assert property (p_cursor_row) else $error("cursor row not lit");

   property p_status;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         !sync_rs[1] |=> DATA_O[7] == $past(busy);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   property p_read_prefetch;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (state == CDH_IDLE && rd_ev && sync_rs[1] && !wr_ev) |=> state == CDH_FETCH;
   endproperty
   a_read_prefetch: assert property (p_read_prefetch) else $error("no prefetch");

   property p_read_step;
      @(posedge MCLK_I) disable iff (!RESETN_I)
         (state == CDH_IDLE && rd_ev && sync_rs[1] && !wr_ev)
            |=> address_counter == step(dir_up, $past(address_counter));
   endproperty
   a_read_step: assert property (p_read_step) else $error("read did not step");
endmodule : cdh_core // cdh_core

// file: tb/cdh_host_model.sv
// host processor model that drives the parallel register port
module cdh_host_model
   import cdh_pkg::*;
(
   input  wire logic        mclk_i,
   output logic             rs_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic [7:0]       data_o,
   input  wire logic [7:0]  data_i,
   input  wire logic        oe_i,
   input  wire logic        busy_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rs_o   = 1'b0;
      wr_o   = 1'b0;
      rd_o   = 1'b0;
      data_o = 8'h00;
   end
   // settle time covers the strobe synchroniser, then a bounded busy poll
   task automatic wait_idle(output logic ok);
      int n;
      ok = 1'b0;
      repeat (6) @(negedge mclk_i);
      for (n = 0; n < 20 && !ok; n++) begin
         if (busy_i === 1'b0) ok = 1'b1;
         else @(negedge mclk_i);
      end
   endtask
   // select and data held from strobe rise until the device is idle again
   task automatic write_reg(input logic s, input logic [7:0] v, output logic ok);
      @(negedge mclk_i);
      rs_o   = s;
      data_o = v;
      wr_o   = 1'b1;
      repeat (3) @(negedge mclk_i);
      wr_o   = 1'b0;
      wait_idle(ok);
      data_o = ~v; // bus no longer shows the last value once released
   endtask
   // read with select low gives status only, never the instruction register
   task automatic read_reg(input logic s, output logic [7:0] v, output logic ok);
      int n;
      ok = 1'b0;
      @(negedge mclk_i);
      rs_o = s;
      rd_o = 1'b1;
      for (n = 0; n < 20 && !ok; n++) begin
         @(negedge mclk_i);
         if (oe_i === 1'b1) ok = 1'b1;
      end
      @(negedge mclk_i);
      v    = data_i;
      rd_o = 1'b0;
      if (ok) wait_idle(ok);
   endtask
endmodule // cdh_host_model

// file: tb/tb_cdh_core.sv
// self-checking bench for the host register pair and glyph ram block
module tb_cdh_core;
   timeunit 1ns;
   timeprecision 1ns;
   import cdh_pkg::*;
   logic       mclk, resetn, rs, wr, rd, oe, busy, use_g, cur, ok;
   logic [7:0] din, dout, code, v, res, a, b;
   logic [2:0] row;
   logic [4:0] dots;
   logic [7:0] pat [8];
   logic [7:0] exp_q [$];
   int         err_total, check_count, i, k;
   event       got;
   cdh_core dut (.MCLK_I(mclk), .RESETN_I(resetn), .REGISTER_SELECT_I(rs), .WR_STROBE_I(wr),
      .RD_STROBE_I(rd), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe), .BUSY_INDICATOR_O(busy),
      .CHAR_CODE_I(code), .ROW_I(row), .CURSOR_I(cur), .USE_GLYPH_RAM_O(use_g), .DOTS_O(dots));
   cdh_host_model host (.mclk_i(mclk), .rs_o(rs), .wr_o(wr), .rd_o(rd), .data_o(din),
      .data_i(dout), .oe_i(oe), .busy_i(busy));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // watcher takes the oldest note whenever a result is presented
   always @(got) begin
      check_count++;
      if (exp_q.size() == 0 || exp_q[0] !== res) begin
         err_total++;
         $display("unexpected at %0t: result %h", $time, res);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // note the expectation, then present the result; the delay keeps res stable
   task automatic check(input logic [7:0] e, input logic [7:0] r);
      exp_q.push_back(e);
      res = r;
      ->got;
      #1;
   endtask
   task automatic wr_op(input logic s, input logic [7:0] d);
      host.write_reg(s, d, ok);
      if (ok !== 1'b1) begin
         err_total++;
         complete_run();
      end
   endtask
   task automatic rd_op(input logic s, output logic [7:0] d);
      host.read_reg(s, d, ok);
      if (ok !== 1'b1) begin
         err_total++;
         complete_run();
      end
   endtask
   // scan inputs held three clocks so the registered dots have settled
   task automatic dot_chk(input logic [7:0] c, input logic [2:0] r, input logic cu,
                          input logic [4:0] e);
      @(negedge mclk);
      code = c;
      row  = r;
      cur  = cu;
      repeat (3) @(negedge mclk);
      check({3'h0, e}, {3'h0, dots});
   endtask
   initial begin
      resetn = 1'b0;
      code   = 8'h00;
      row    = 3'h0;
      cur    = 1'b0;
      void'($urandom(77253));
      repeat (8) @(negedge mclk);
      resetn = 1'b1;
      repeat (2) @(negedge mclk);
      rd_op(1'b0, v);
      check(8'h00, v);
      $display("test reset status done");
      // fill one user glyph back to back, counter stepping up
      k = $urandom_range(6);
      wr_op(1'b0, SET_GLYPH_ADR | 8'(k * 8));
      for (i = 0; i < 8; i++) begin
         pat[i] = 8'($urandom);
         wr_op(1'b1, pat[i]);
      end
      rd_op(1'b0, v);
      check(8'((k + 1) * 8), v);
      wr_op(1'b0, SET_GLYPH_ADR | 8'(k * 8 + 2));
      rd_op(1'b1, v);
      check(pat[2], v);
      rd_op(1'b1, v);
      check(pat[3], v);
      $display("test glyph ram done");
      // every row, code bit 3 random, upper pattern bits random
      for (i = 0; i < 8; i++) begin
         dot_chk({4'h0, 1'($urandom), 3'(k)}, 3'(i), 1'b0, pat[i][4:0]);
      end
      dot_chk({4'h0, 1'b1, 3'(k)}, CURSOR_ROW, 1'b1, 5'h1f);
      for (i = 0; i < 10; i++) begin
         @(negedge mclk);
         code = (i == 0) ? 8'h0f : (i == 1) ? 8'h10 : 8'($urandom_range(40));
         #1;
         check({7'h0, code[7:4] == 4'h0}, {7'h0, use_g});
      end
      $display("test glyph display done");
      // text ram with the counter stepping down
      a = 8'($urandom);
      b = ~a;
      wr_op(1'b0, SET_DIR);
      wr_op(1'b0, SET_TEXT_ADR | 8'h05);
      wr_op(1'b1, a);
      wr_op(1'b1, b);
      rd_op(1'b0, v);
      check(8'h03, v);
      wr_op(1'b0, SET_TEXT_ADR | 8'h04);
      rd_op(1'b1, v);
      check(b, v);
      wr_op(1'b0, SET_TEXT_ADR | 8'h05);
      rd_op(1'b1, v);
      check(a, v);
      rd_op(1'b1, v);
      check(b, v);
      $display("test text ram done");
      complete_run();
   end
endmodule // tb_cdh_core
